// *** dbp_pwm_top.sv ***
// double-buffered 10-bit pwm with bridge steering and dead band, axi4-lite registers
`include "dbp_defines.svh"

module dbp_pwm_top
    import dbp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pwm_output_pin_in,
    output logic             pwm_output_pin_out,
    output logic             pwm_output_pin_oe_n,
    output logic             bridge_output_b,
    output logic             bridge_output_c,
    output logic             bridge_output_d
);

    logic [7:0]       module_control;
    logic [7:0]       period_register;
    logic [7:0]       duty_value_low;
    logic [7:0]       duty_value_buffer;
    logic [1:0]       duty_lsb_latch;
    logic [7:0]       timebase_timer;
    logic [2:0]       timer_control;
    logic [7:0]       dead_band_delay;
    logic [7:0]       port_c_direction;
    logic [7:0]       port_c_latch;
    logic [5:0]       phase_count;
    logic             pwm_latch;
    logic [9:0]       dead_count;
    dbp_db_state_type db_state;
    dbp_db_state_type next_db_state;
    logic [31:0]      aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;

    // ---------------- bus slave ----------------
    wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire lane0    = w_strb[0];
    wire wr_ctrl  = do_write && lane0 && (aw_addr == `DBP_OFF_CTRL);
    wire wr_per   = do_write && lane0 && (aw_addr == `DBP_OFF_PERIOD);
    wire wr_dlow  = do_write && lane0 && (aw_addr == `DBP_OFF_DUTY_LOW);
    wire wr_dbuf  = do_write && lane0 && (aw_addr == `DBP_OFF_DUTY_BUF);
    wire wr_tctl  = do_write && lane0 && (aw_addr == `DBP_OFF_TCTRL);
    wire wr_dly   = do_write && lane0 && (aw_addr == `DBP_OFF_DELAY);
    wire wr_dir   = do_write && lane0 && (aw_addr == `DBP_OFF_DIR);
    wire wr_lat   = do_write && lane0 && (aw_addr == `DBP_OFF_LATCH);
    wire wr_known = (aw_addr == `DBP_OFF_CTRL) || (aw_addr == `DBP_OFF_PERIOD)
                 || (aw_addr == `DBP_OFF_DUTY_LOW) || (aw_addr == `DBP_OFF_DUTY_BUF)
                 || (aw_addr == `DBP_OFF_TIMER) || (aw_addr == `DBP_OFF_TCTRL)
                 || (aw_addr == `DBP_OFF_DELAY) || (aw_addr == `DBP_OFF_DIR)
                 || (aw_addr == `DBP_OFF_LATCH) || (aw_addr == `DBP_OFF_PINS);

    wire pwm_mode = module_control[`DBP_CTRL_MODE_HI:`DBP_CTRL_MODE_LO] == `DBP_MODE_PWM;
    wire ctrl_clear = wr_ctrl && (w_data[7:0] == `DBP_RST_CTRL);

    logic [31:0] rd_word;
    logic        rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (s_axi_araddr)
            `DBP_OFF_CTRL:     rd_word = {24'h00_0000, module_control};
            `DBP_OFF_PERIOD:   rd_word = {24'h00_0000, period_register};
            `DBP_OFF_DUTY_LOW: rd_word = {24'h00_0000, duty_value_low};
            `DBP_OFF_DUTY_BUF: rd_word = {22'h00_0000, duty_value_buffer, duty_lsb_latch};
            `DBP_OFF_TIMER:    rd_word = {24'h00_0000, timebase_timer};
            `DBP_OFF_TCTRL:    rd_word = {29'h0000_0000, timer_control};
            `DBP_OFF_DELAY:    rd_word = {24'h00_0000, dead_band_delay};
            `DBP_OFF_DIR:      rd_word = {24'h00_0000, port_c_direction};
            `DBP_OFF_LATCH:    rd_word = {24'h00_0000, port_c_latch};
            `DBP_OFF_PINS:     rd_word = {31'h0000_0000, pwm_output_pin_in};
            default: begin
                rd_word  = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DBP_RESP_OKAY;
            aw_addr       <= 32'h0000_0000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `DBP_RESP_OKAY : `DBP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DBP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_known ? `DBP_RESP_OKAY : `DBP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            module_control   <= `DBP_RST_CTRL;
            period_register  <= `DBP_RST_PERIOD;
            duty_value_low   <= `DBP_RST_ZERO8;
            timer_control    <= 3'h0;
            dead_band_delay  <= `DBP_RST_ZERO8;
            port_c_direction <= `DBP_RST_DIR;
            port_c_latch     <= `DBP_RST_ZERO8;
        end else begin
            if (wr_ctrl)
                module_control <= w_data[7:0];
            if (wr_per)
                period_register <= w_data[7:0];
            if (wr_dlow)
                duty_value_low <= w_data[7:0];
            if (wr_tctl)
                timer_control <= w_data[2:0];
            if (wr_dly)
                dead_band_delay <= w_data[7:0];
            if (wr_dir)
                port_c_direction <= w_data[7:0];
            if (wr_lat)
                port_c_latch <= w_data[7:0];
        end
    end

    // ---------------- timebase ----------------
    // four clock phases per timer tick, times the prescale
    wire [5:0] phase_term = (timer_control[1:0] == 2'h0) ? `DBP_TERM_P1 :
                            (timer_control[1:0] == 2'h1) ? `DBP_TERM_P4 : `DBP_TERM_P16;
    wire       timer_on   = timer_control[`DBP_TCTRL_ON];
    wire       tick       = timer_on && (phase_count == phase_term);
    wire       period_end = tick && (timebase_timer == period_register);
    // the two extra compare bits are the phase counter's top two bits for each prescale
    wire [1:0] low_bits   = (timer_control[1:0] == 2'h0) ? phase_count[1:0] :
                            (timer_control[1:0] == 2'h1) ? phase_count[3:2] :
                                                           phase_count[5:4];
    wire [9:0] duty_new   = {duty_value_low,
                             module_control[`DBP_CTRL_LSB_HI:`DBP_CTRL_LSB_LO]};
    // last clock of a compare step: clearing there gives exactly duty times prescale clocks
    wire       sub_last   = (timer_control[1:0] == 2'h0) || ((timer_control[1:0] == 2'h1) ?
                            (phase_count[1:0] == 2'h3) : (phase_count[3:0] == 4'hF));
    wire       duty_hit   = sub_last && (({duty_value_buffer, duty_lsb_latch} - 10'h001)
                            == {timebase_timer, low_bits});

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_count    <= 6'h00;
            timebase_timer <= 8'h00;
        end else if (!timer_on) begin
            phase_count <= 6'h00;
        end else if (tick) begin
            phase_count <= 6'h00;
            // period is (period+1) ticks of four phases times prescale
            timebase_timer <= period_end ? 8'h00 : timebase_timer + 8'h01;
        end else begin
            phase_count <= phase_count + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_value_buffer <= `DBP_RST_ZERO8;
            duty_lsb_latch    <= 2'h0;
        end else if (pwm_mode && period_end) begin
            duty_value_buffer <= duty_new[9:2];
            duty_lsb_latch    <= duty_new[1:0];
        end else if (wr_dbuf && !pwm_mode) begin
            // writes in pwm mode fall through untouched
            duty_value_buffer <= w_data[9:2];
            duty_lsb_latch    <= w_data[1:0];
        end
    end

    // ---------------- pwm latch ----------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            pwm_latch <= 1'b0;
        else if (ctrl_clear || !pwm_mode)
            pwm_latch <= 1'b0;
        else if (period_end)
            pwm_latch <= (duty_new != 10'h000);
        else if (duty_hit)
            pwm_latch <= 1'b0;
    end

    // ---------------- dead band ----------------
    // a pulse shorter than the dead band never turns the opposite side on
    wire [9:0] dead_load = {dead_band_delay, 2'h0} - 10'h001;
    wire       dead_zero = (dead_band_delay == 8'h00);
    wire       dead_done = (dead_count == 10'h000);

    always_comb begin
        case (db_state)
            DBP_DB_A_ON:
                next_db_state = !pwm_latch ? (dead_zero ? DBP_DB_B_ON : DBP_DB_TO_B)
                                           : DBP_DB_A_ON;
            DBP_DB_TO_B:
                next_db_state = pwm_latch ? DBP_DB_A_ON :
                                dead_done ? DBP_DB_B_ON : DBP_DB_TO_B;
            DBP_DB_B_ON:
                next_db_state = pwm_latch ? (dead_zero ? DBP_DB_A_ON : DBP_DB_TO_A)
                                          : DBP_DB_B_ON;
            DBP_DB_TO_A:
                next_db_state = !pwm_latch ? DBP_DB_B_ON :
                                dead_done ? DBP_DB_A_ON : DBP_DB_TO_A;
            default:
                next_db_state = DBP_DB_B_ON;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            db_state   <= DBP_DB_B_ON;
            dead_count <= 10'h000;
        end else begin
            db_state <= next_db_state;
            if (next_db_state != db_state)
                dead_count <= dead_load;
            else if (!dead_done)
                dead_count <= dead_count - 10'h001;
        end
    end

    // ---------------- output steering ----------------
    wire         half_a = (db_state == DBP_DB_A_ON);
    wire         half_b = (db_state == DBP_DB_B_ON);
    dbp_cfg_type cfg;
    assign cfg = dbp_cfg_type'(module_control[`DBP_CTRL_CFG_HI:`DBP_CTRL_CFG_LO]);
    logic act_a;
    logic act_b;
    logic act_c;
    logic act_d;
    always_comb begin
        act_a = 1'b0;
        act_b = 1'b0;
        act_c = 1'b0;
        act_d = 1'b0;
        if (pwm_mode) begin
            case (cfg)
                DBP_CFG_SINGLE: act_a = pwm_latch;
                DBP_CFG_HALF: begin
                    act_a = half_a;
                    act_b = half_b;
                end
                DBP_CFG_FWD: begin
                    act_a = 1'b1;
                    act_d = pwm_latch;
                end
                DBP_CFG_REV: begin
                    act_c = 1'b1;
                    act_b = pwm_latch;
                end
                default: act_a = 1'b0;
            endcase
        end
    end

    // polarity bit set means active low; outside pwm mode polarity is ignored and the bridge outputs sit low
    wire pol_ac = pwm_mode && module_control[`DBP_CTRL_POL_AC];
    wire pol_bd = pwm_mode && module_control[`DBP_CTRL_POL_BD];
    wire next_pin = pwm_mode ? (act_a ^ pol_ac)
                             : port_c_latch[`DBP_PIN_BIT];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_output_pin_out  <= 1'b0;
            pwm_output_pin_oe_n <= 1'b1;
            bridge_output_b     <= 1'b0;
            bridge_output_c     <= 1'b0;
            bridge_output_d     <= 1'b0;
        end else begin
            pwm_output_pin_out  <= next_pin;
            pwm_output_pin_oe_n <= port_c_direction[`DBP_PIN_BIT];
            bridge_output_b     <= act_b ^ pol_bd;
            bridge_output_c     <= act_c ^ pol_ac;
            bridge_output_d     <= act_d ^ pol_bd;
        end
    end

endmodule : dbp_pwm_top

// *** dbp_defines.svh ***
// register offsets, field positions, reset values and timing counts of the pwm block
`ifndef DBP_DEFINES_SVH
`define DBP_DEFINES_SVH
`define DBP_OFF_CTRL      32'h0000_0000
`define DBP_OFF_PERIOD    32'h0000_0004
`define DBP_OFF_DUTY_LOW  32'h0000_0008
`define DBP_OFF_DUTY_BUF  32'h0000_000C
`define DBP_OFF_TIMER     32'h0000_0010
`define DBP_OFF_TCTRL     32'h0000_0014
`define DBP_OFF_DELAY     32'h0000_0018
`define DBP_OFF_DIR       32'h0000_001C
`define DBP_OFF_LATCH     32'h0000_0020
`define DBP_OFF_PINS      32'h0000_0024
`define DBP_CTRL_CFG_HI   7
`define DBP_CTRL_CFG_LO   6
`define DBP_CTRL_LSB_HI   5
`define DBP_CTRL_LSB_LO   4
`define DBP_CTRL_MODE_HI  3
`define DBP_CTRL_MODE_LO  2
`define DBP_CTRL_POL_AC   1
`define DBP_CTRL_POL_BD   0
`define DBP_MODE_PWM      2'h3
`define DBP_TCTRL_ON      2
`define DBP_PIN_BIT       2
`define DBP_RST_CTRL      8'h00
`define DBP_RST_PERIOD    8'hFF
`define DBP_RST_DIR       8'hFF
`define DBP_RST_ZERO8     8'h00
`define DBP_PHASES        8'h04
`define DBP_TERM_P1       6'h03
`define DBP_TERM_P4       6'h0F
`define DBP_TERM_P16      6'h3F
`define DBP_RESP_OKAY     2'h0
`define DBP_RESP_SLVERR   2'h2
`endif

// *** dbp_pkg.sv ***
// types shared by the pwm block
package dbp_pkg;
    typedef enum logic [1:0] {
        DBP_CFG_SINGLE = 2'h0,
        DBP_CFG_FWD    = 2'h1,
        DBP_CFG_HALF   = 2'h2,
        DBP_CFG_REV    = 2'h3
    } dbp_cfg_type;
    typedef enum logic [3:0] {
        DBP_DB_A_ON  = 4'h1,
        DBP_DB_TO_B  = 4'h2,
        DBP_DB_B_ON  = 4'h4,
        DBP_DB_TO_A  = 4'h8
    } dbp_db_state_type;
endpackage : dbp_pkg

// *** dbp_pwm_props.sv ***
// bus timing and bridge steering assertions for the pwm block
`include "dbp_defines.svh"

module dbp_pwm_props (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pwm_output_pin_out,
    input wire logic        bridge_output_b,
    input wire logic        bridge_output_c,
    input wire logic        bridge_output_d
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] ctl;
    logic [6:0] age;
    logic       take_w;
    logic       settled;
    logic       pwm_on;
    assign take_w  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign settled = (age == 7'h7F);
    assign pwm_on  = settled && (ctl[3:2] == 2'h3);
    // steering follows a control write a few clocks later through the bus and output registers, so allow settle time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= 8'h00;
            age <= 7'h00;
        end else if (take_w && (s_axi_awaddr == `DBP_OFF_CTRL) && s_axi_wstrb[0]) begin
            ctl <= s_axi_wdata[7:0];
            age <= 7'h00;
        end else if (!settled) begin
            age <= age + 7'h01;
        end
    end
    sequence s_write_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_answer_time: assert property (take_w |=> s_write_answer)
        else $error("write response late or early");
    a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_fwd_steering: assert property (pwm_on && ctl[7:6] == 2'h1 |->
        pwm_output_pin_out == !ctl[1] && bridge_output_b == ctl[0] && bridge_output_c == ctl[1])
        else $error("forward steering wrong");
    a_rev_steering: assert property (pwm_on && ctl[7:6] == 2'h3 |->
        pwm_output_pin_out == ctl[1] && bridge_output_c == !ctl[1] && bridge_output_d == ctl[0])
        else $error("reverse steering wrong");
    a_half_no_overlap: assert property (pwm_on && ctl[7:6] == 2'h2 |->
        !((pwm_output_pin_out ^ ctl[1]) && (bridge_output_b ^ ctl[0])))
        else $error("half bridge outputs overlap");
    a_idle_bridge_low: assert property (settled && ctl[3:2] != 2'h3 |->
        !bridge_output_b && !bridge_output_c && !bridge_output_d) else $error("bridge not idle");
endmodule : dbp_pwm_props

// *** dbp_load_model.sv ***
// load model: resolves the shared pin and times the pulses it sees
module dbp_load_model (
    input  wire logic   sys_clk,
    input  wire logic   pin_out,
    input  wire logic   pin_oe_n,
    input  wire logic   out_b,
    output logic        pin_level,
    output logic [15:0] high_len,
    output logic [15:0] per_len,
    output logic [15:0] gap_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        last = 1'b0;
    logic        prev_a = 1'b0;
    logic        prev_b = 1'b0;
    logic [15:0] hi_cnt = 16'h0000;
    logic [15:0] per_cnt = 16'h0000;
    logic [15:0] gap_cnt = 16'h0000;
    // no pull on the pin: a released pin shows the inverse of the last level, never a stale one
    assign pin_level = pin_oe_n ? !last : pin_out;
    always @(posedge sys_clk) begin
        if (!pin_oe_n) last <= pin_out;
        hi_cnt  <= pin_level ? hi_cnt + 16'h0001 : 16'h0000;
        gap_cnt <= (pin_level || out_b) ? 16'h0000 : gap_cnt + 16'h0001;
        per_cnt <= (pin_level && !prev_a) ? 16'h0001 : per_cnt + 16'h0001;
        if (!pin_level && hi_cnt != 16'h0000) high_len <= hi_cnt;
        if (pin_level && !prev_a) per_len <= per_cnt;
        if (out_b && !prev_b) gap_len <= gap_cnt;
        prev_a <= pin_level;
        prev_b <= out_b;
    end
endmodule : dbp_load_model

// *** dbp_pwm_tb_top.sv ***
// self-checking bench for the double-buffered pwm block
`include "dbp_defines.svh"

module dbp_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        reset_n;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        pwm_output_pin_in, pwm_output_pin_out, pwm_output_pin_oe_n;
    logic        bridge_output_b, bridge_output_c, bridge_output_d;
    logic [15:0] high_len, per_len, gap_len;
    logic [31:0] cfg_tab [3] = '{32'h0000_005F, 32'h0000_00DD, 32'h0000_009C};
    int          bad_count = 0;
    int          samples_checked = 0;

    dbp_pwm_top u_dut (.*);
    dbp_load_model u_load (.sys_clk(sys_clk), .pin_out(pwm_output_pin_out),
        .pin_oe_n(pwm_output_pin_oe_n), .out_b(bridge_output_b), .pin_level(pwm_output_pin_in),
        .high_len(high_len), .per_len(per_len), .gap_len(gap_len));

    always #2 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // address and data are offered together; each is dropped once its own ready is seen
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge sys_clk);
            ta = ta || (s_axi_awready === 1'b1);
            tw = tw || (s_axi_wready === 1'b1);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    initial begin
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`DBP_OFF_PERIOD, v);
        chk(v, 32'h0000_00FF, "period reset");
        chk(32'(pwm_output_pin_oe_n), 32'h0000_0001, "pin released");
        wr(32'h0000_0040, 32'h0000_0001);
        chk(32'(last_resp), 32'h0000_0002, "unmapped response");
        rd(32'h0000_0040, v);
        chk(32'(last_resp), 32'h0000_0002, "unmapped read response");
        chk(v, 32'h0000_0000, "unmapped read data");
        $display("test reset done");
        wr(`DBP_OFF_DIR, 32'h0000_00FB);
        wr(`DBP_OFF_PERIOD, 32'h0000_0009);
        wr(`DBP_OFF_DUTY_LOW, 32'h0000_0003);
        wr(`DBP_OFF_CTRL, 32'h0000_001C);
        for (int i = 0; i < 3; i++) begin
            wr(`DBP_OFF_TCTRL, 32'h0000_0004 + i);
            repeat (100 << (2 * i)) @(negedge sys_clk);
            chk(32'(per_len), 40 << (2 * i), "period length");
            chk(32'(high_len), 13 << (2 * i), "high length");
        end
        chk(32'(pwm_output_pin_oe_n), 32'h0000_0000, "pin driven");
        $display("test prescale done");
        wr(`DBP_OFF_TCTRL, 32'h0000_0004);
        @(posedge pwm_output_pin_in);
        wr(`DBP_OFF_DUTY_LOW, 32'h0000_0007);
        wr(`DBP_OFF_CTRL, 32'h0000_002C);
        wr(`DBP_OFF_DUTY_BUF, 32'h0000_0005);
        rd(`DBP_OFF_DUTY_BUF, v);
        chk(v, 32'h0000_000D, "buffer before match");
        repeat (100) @(negedge sys_clk);
        rd(`DBP_OFF_DUTY_BUF, v);
        chk(v, 32'h0000_001E, "buffer after match");
        chk(32'(high_len), 32'h0000_001E, "new high length");
        wr(`DBP_OFF_DUTY_LOW, 32'h0000_0000);
        wr(`DBP_OFF_CTRL, 32'h0000_000C);
        repeat (50) @(negedge sys_clk);
        v = 32'h0000_0000;
        repeat (80) begin
            @(negedge sys_clk);
            v[0] = v[0] | pwm_output_pin_out;
        end
        chk(v, 32'h0000_0000, "zero duty pin");
        $display("test duty done");
        wr(`DBP_OFF_DUTY_LOW, 32'h0000_0003);
        wr(`DBP_OFF_CTRL, 32'h0000_001E);
        repeat (200) @(negedge sys_clk);
        chk(32'(high_len), 32'h0000_001B, "active low single");
        wr(`DBP_OFF_DELAY, 32'h0000_0002);
        foreach (cfg_tab[i]) begin
            wr(`DBP_OFF_CTRL, cfg_tab[i]);
            repeat (200) @(negedge sys_clk);
        end
        chk(32'(gap_len), 32'h0000_0008, "dead band");
        $display("test steering done");
        wr(`DBP_OFF_LATCH, 32'h0000_0004);
        wr(`DBP_OFF_CTRL, 32'h0000_0000);
        repeat (150) @(negedge sys_clk);
        chk(32'(pwm_output_pin_out), 32'h0000_0001, "port latch on pin");
        rd(`DBP_OFF_LATCH, v);
        chk(v, 32'h0000_0004, "port latch kept");
        $display("test disable done");
        final_report();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end
endmodule : dbp_pwm_tb_top

bind dbp_pwm_top dbp_pwm_props u_props (.*);
